// File: rtl/pvip_defines.svh
// Constants of the parallel video input port: register map, fields,
// reset values and filter length. Assumes inclusion by pvip_top and test_pvip_top.
`ifndef PVIP_DEFINES_SVH
`define PVIP_DEFINES_SVH

// Register byte offsets
`define PVIP_CTRL_OFS     8'h00
`define PVIP_GPIO_OFS     8'h04
`define PVIP_STAT_OFS     8'h08

// Control register fields and reset value
`define PVIP_CTRL_FILT    0
`define PVIP_CTRL_EDGE    1
`define PVIP_CTRL_M18     2
`define PVIP_CTRL_MASK    32'h0000_0007
`define PVIP_CTRL_RST     32'h0000_0001

// Pin register fields and reset value
`define PVIP_GPIO_OUT     0
`define PVIP_GPIO_DIR     4
`define PVIP_RDO_EN       8
`define PVIP_RDO_VAL      12
`define PVIP_GPIO_MASK    32'h0000_ffff
`define PVIP_GPIO_RST     32'h0000_0000

// Status register fields
`define PVIP_STAT_GPIO    0
`define PVIP_STAT_M18     4
`define PVIP_STAT_ADDR    5
`define PVIP_STAT_AVALID  12

// Samples a filtered control level must hold before it is taken
`define PVIP_FILT_LEN     3

`endif

// File: rtl/pvip_pkg.sv
// Types of the parallel video input port.
// Assumes the pixel pins are grouped as one packed word.
`default_nettype none

package pvip_pkg;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       horizontal_sync;
        logic       vertical_sync;
        logic       pixel_valid;
        logic       audio_word_clk;
        logic       audio_data;
    } pvip_pins_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       horizontal_sync;
        logic       vertical_sync;
        logic       pixel_valid;
        logic       second_audio_data;
    } pvip_word_t;

    typedef struct packed {
        logic blue1_out;
        logic blue0_out;
        logic mode18;
        logic edge_fall;
        logic filter_en;
    } pvip_cfg_t;

endpackage : pvip_pkg

`default_nettype wire

// File: rtl/pvip_top.sv
// Parallel video input port: pixel capture, control filter, pin sharing,
// power-down and bus address choice, with a classic Wishbone slave.
// Assumes pixel_clk_i runs while power_down_n_i is high.
//
// Overview of operation
// RULE1 - With filter on, pass sync or valid pulses only when at least 3 clocks; the code leaves vertical sync unfiltered.
// RULE2 - With filter off, pass sync and valid changes with no minimum width.
// RULE3 - Source toggles sync and valid at most twice per 130 pixel clocks.
// RULE4 - Source toggles vertical sync at most once per 130 pixel clocks.
// RULE5 - Sample pixel inputs on rising or falling pixel clock edge per config.
// RULE6 - Run normally while power-down input high, power down while low.
// RULE7 - Powered down: serial outputs both high, PLL stopped, registers reset.
// RULE8 - Four two-way general pins exist only in 18-bit colour mode.
// RULE9 - Green bits 0 and 1 serve as general pins 2 and 3.
// RULE10 - Blue bits 0 and 1 serve as register outputs 4 and 5.
// RULE11 - Audio word clock and data pins serve as register outputs 7 and 6.
// RULE12 - In 18-bit mode blue bit 1 carries second audio data input.
// RULE13 - Each register output pin follows its register bit when used as output.
// RULE14 - Bus target address follows the level on the address select pin; the code takes it once after each power-up.
// RULE15 - Red bits 0 and 1 serve as general pins 0 and 1.
// RULE16 - Filter takes a new level after three equal consecutive samples.
// RULE17 - Power-down acts as asynchronous reset, released on the pixel clock.
`default_nettype none

module pvip_top
    import pvip_pkg::*;
#(
    parameter logic [6:0] ADDR_SEL0 = 7'h10,
    parameter logic [6:0] ADDR_SEL1 = 7'h11,
    parameter logic [6:0] ADDR_SEL2 = 7'h12,
    parameter logic [6:0] ADDR_SEL3 = 7'h13
) (
    // System clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Wishbone slave
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    // Pixel side
    input  wire logic       pixel_clk_i,
    input  wire pvip_pins_t pins_i,
    output var pvip_word_t  word_o,
    output logic            link_p_o,
    output logic            link_n_o,
    output logic            pll_run_o,
    // Device pins
    input  wire logic       power_down_n_i,
    input  wire logic       mode_select_i,
    input  wire logic [1:0] bus_address_select_i,
    output logic [3:0]      gpio_o,
    output logic [3:0]      gpio_oe_n_o,
    output logic [3:0]      register_driven_output_o,
    output logic [3:0]      register_driven_output_oe_n_o,
    output logic [6:0]      i2c_target_addr_o
);

    `include "pvip_defines.svh"

    localparam int PW = 8;
    localparam int HW = `PVIP_FILT_LEN - 1;

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction : lane_mask

    function automatic logic [2:0] reg_dec(input logic [7:0] adr);
        return {adr == `PVIP_STAT_OFS, adr == `PVIP_GPIO_OFS, adr == `PVIP_CTRL_OFS};
    endfunction : reg_dec

    function automatic logic [6:0] addr_decode(input logic [1:0] sel);
        case (sel)
            2'h0: return ADDR_SEL0;
            2'h1: return ADDR_SEL1;
            2'h2: return ADDR_SEL2;
            default: return ADDR_SEL3;
        endcase
    endfunction : addr_decode

    // ---------------- System clock domain ----------------

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_s1_reg;
    logic [PW-1:0] pin_s2_reg;
    logic [PW-1:0] pin_s3_reg;
    logic [PW-1:0] pin_st_reg;
    logic          pd_ok;
    logic          m18_pin;
    logic [3:0]    gpio_in;
    logic [1:0]    asel;
    logic          reg_clr;
    logic [31:0]   ctrl_reg;
    logic [31:0]   gpio_reg;
    logic          addr_valid_reg;
    logic          m18;
    logic [3:0]    rdo_en;
    logic [2:0]    dec;
    logic          req;
    logic [31:0]   wmask;
    logic [31:0]   stat;
    pvip_cfg_t     cfg_reg;

    assign pin_raw = {bus_address_select_i, pins_i.green[1:0], pins_i.red[1:0],
                      mode_select_i, power_down_n_i};
    assign pd_ok   = pin_st_reg[0];
    assign m18_pin = pin_st_reg[1];
    assign gpio_in = pin_st_reg[5:2];
    assign asel    = pin_st_reg[7:6];

    // A pin change counts only once the second and third stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            pin_st_reg <= '0;
        end else if (ce_i) begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_st_reg <= (pin_s2_reg & pin_s3_reg) | (pin_st_reg & (pin_s2_reg ^ pin_s3_reg));
        end
    end

    assign reg_clr = rst_i | ~pd_ok; // RULE7
    assign dec     = reg_dec(wb_adr_i);
    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wmask   = lane_mask(wb_sel_i);
    assign m18     = ctrl_reg[`PVIP_CTRL_M18] | m18_pin; // RULE8
    // Blue bit 1 belongs to the second audio input in 18-bit mode
    assign rdo_en  = gpio_reg[`PVIP_RDO_EN +: 4] & {2'b11, ~m18, 1'b1}; // RULE12

    always_ff @(posedge clk_i) begin
        if (reg_clr) begin
            ctrl_reg <= `PVIP_CTRL_RST; // RULE7
            gpio_reg <= `PVIP_GPIO_RST; // RULE7
        end else if (ce_i && req && wb_we_i) begin
            if (dec[0]) begin
                ctrl_reg <= ((ctrl_reg & ~wmask) | (wb_dat_i & wmask)) & `PVIP_CTRL_MASK;
            end
            if (dec[1]) begin
                gpio_reg <= ((gpio_reg & ~wmask) | (wb_dat_i & wmask)) & `PVIP_GPIO_MASK;
            end
        end
    end

    always_comb begin
        stat = '0;
        stat[`PVIP_STAT_GPIO +: 4] = gpio_in;
        stat[`PVIP_STAT_M18]       = m18;
        stat[`PVIP_STAT_ADDR +: 7] = i2c_target_addr_o;
        stat[`PVIP_STAT_AVALID]    = addr_valid_reg;
    end

    // Fixed one-wait answer; unmapped offsets read zero, writes ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= dec[0] ? ctrl_reg :
                            dec[1] ? gpio_reg :
                            dec[2] ? stat : 32'h0000_0000;
            end
        end
    end

    // Address is taken once after every power-up, not tracked live
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_valid_reg    <= 1'b0;
            i2c_target_addr_o <= '0;
        end else if (ce_i) begin
            if (!pd_ok) begin
                addr_valid_reg <= 1'b0;
            end else if (!addr_valid_reg) begin
                addr_valid_reg    <= 1'b1;
                i2c_target_addr_o <= addr_decode(asel); // RULE14
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reg_clr) begin
            gpio_o                        <= '0;
            gpio_oe_n_o                   <= '1;
            register_driven_output_o      <= '0;
            register_driven_output_oe_n_o <= '1;
        end else if (ce_i) begin
            gpio_o      <= gpio_reg[`PVIP_GPIO_OUT +: 4]; // RULE9 RULE15
            gpio_oe_n_o <= ~(gpio_reg[`PVIP_GPIO_DIR +: 4] & {4{m18}}); // RULE8
            register_driven_output_o      <= gpio_reg[`PVIP_RDO_VAL +: 4]; // RULE13
            register_driven_output_oe_n_o <= ~rdo_en; // RULE10 RULE11
        end
    end

    // Quasi-static settings; software must let the pixel side settle
    always_ff @(posedge clk_i) begin
        if (reg_clr) begin
            cfg_reg <= '0;
        end else if (ce_i) begin
            cfg_reg.filter_en <= ctrl_reg[`PVIP_CTRL_FILT];
            cfg_reg.edge_fall <= ctrl_reg[`PVIP_CTRL_EDGE];
            cfg_reg.mode18    <= m18;
            cfg_reg.blue0_out <= rdo_en[0];
            cfg_reg.blue1_out <= rdo_en[1];
        end
    end

    // ---------------- Pixel clock domain ----------------

    logic        prst1_reg;
    logic        prst_n;
    pvip_cfg_t   cfg_s1_reg;
    pvip_cfg_t   cfg;
    pvip_pins_t  neg_reg;
    pvip_pins_t  samp_reg;
    logic [1:0]  ctl_s;
    logic [1:0]  ctl_cur;
    logic [1:0]  ctl_next;
    logic [HW-1:0] hist_reg [2];

    always_ff @(posedge pixel_clk_i or negedge power_down_n_i) begin
        if (!power_down_n_i) begin
            prst1_reg <= 1'b0; // RULE17
            prst_n    <= 1'b0; // RULE6
        end else begin
            prst1_reg <= 1'b1;
            prst_n    <= prst1_reg;
        end
    end

    always_ff @(posedge pixel_clk_i or negedge prst_n) begin
        if (!prst_n) begin
            cfg_s1_reg <= '0;
            cfg        <= '0;
        end else begin
            cfg_s1_reg <= cfg_reg;
            cfg        <= cfg_s1_reg;
        end
    end

    always_ff @(negedge pixel_clk_i or negedge prst_n) begin
        if (!prst_n) begin
            neg_reg <= '0;
        end else begin
            neg_reg <= pins_i;
        end
    end

    // Falling-edge data is half a clock old when the rising edge takes it
    always_ff @(posedge pixel_clk_i or negedge prst_n) begin
        if (!prst_n) begin
            samp_reg <= '0;
        end else begin
            samp_reg <= cfg.edge_fall ? neg_reg : pins_i; // RULE5
        end
    end

    assign ctl_s   = {samp_reg.pixel_valid, samp_reg.horizontal_sync};
    assign ctl_cur = {word_o.pixel_valid, word_o.horizontal_sync};

    for (genvar gi = 0; gi < 2; gi++) begin : g_filt
        always_ff @(posedge pixel_clk_i or negedge prst_n) begin
            if (!prst_n) begin
                hist_reg[gi] <= '0;
            end else begin
                hist_reg[gi] <= {hist_reg[gi][HW-2:0], ctl_s[gi]};
            end
        end
        assign ctl_next[gi] = (!cfg.filter_en) ? ctl_s[gi] : // RULE2
                              (hist_reg[gi] == {HW{ctl_s[gi]}}) ? ctl_s[gi] : // RULE1 RULE16
                              ctl_cur[gi];
    end

    always_ff @(posedge pixel_clk_i or negedge prst_n) begin
        if (!prst_n) begin
            word_o <= '0;
        end else begin
            word_o.red     <= cfg.mode18 ? {samp_reg.red[7:2], 2'b00} : samp_reg.red; // RULE15
            word_o.green   <= cfg.mode18 ? {samp_reg.green[7:2], 2'b00} : samp_reg.green; // RULE9
            word_o.blue[7:2] <= samp_reg.blue[7:2];
            word_o.blue[0] <= samp_reg.blue[0] & ~cfg.blue0_out; // RULE10
            word_o.blue[1] <= samp_reg.blue[1] & ~cfg.blue1_out & ~cfg.mode18; // RULE12
            word_o.second_audio_data <= samp_reg.blue[1] & cfg.mode18; // RULE12
            word_o.horizontal_sync   <= ctl_next[0];
            word_o.pixel_valid       <= ctl_next[1];
            word_o.vertical_sync     <= samp_reg.vertical_sync;
        end
    end

    // Line stand-in: parity of the word; the real line coder lives elsewhere
    always_ff @(posedge pixel_clk_i or negedge prst_n) begin
        if (!prst_n) begin
            link_p_o  <= 1'b1; // RULE7
            link_n_o  <= 1'b1; // RULE7
            pll_run_o <= 1'b0; // RULE7
        end else begin
            link_p_o  <= ^word_o;
            link_n_o  <= ~(^word_o);
            pll_run_o <= 1'b1; // RULE6
        end
    end

    // ---------------- Checks ----------------

    a_filter_min_width: assert property ( // RULE1
        @(posedge pixel_clk_i) disable iff (!prst_n)
        ($past(cfg.filter_en) && $changed(word_o.horizontal_sync))
        |-> ($past(samp_reg.horizontal_sync) == word_o.horizontal_sync)
            && ($past(hist_reg[0]) == {HW{word_o.horizontal_sync}}))
        else $error("horizontal sync passed a pulse shorter than three clocks");

    a_filter_three_equal: assert property ( // RULE16
        @(posedge pixel_clk_i) disable iff (!prst_n)
        (cfg.filter_en && samp_reg.pixel_valid == 1'b1 && hist_reg[1] == 2'b11)
        |=> word_o.pixel_valid)
        else $error("pixel valid not taken after three equal samples");

    a_filter_bypass: assert property ( // RULE2
        @(posedge pixel_clk_i) disable iff (!prst_n)
        !cfg.filter_en |=> (word_o.horizontal_sync == $past(samp_reg.horizontal_sync))
            && (word_o.pixel_valid == $past(samp_reg.pixel_valid)))
        else $error("unfiltered control level not passed straight");

    a_strobe_edge: assert property ( // RULE5
        @(posedge pixel_clk_i) disable iff (!prst_n)
        cfg.edge_fall |=> samp_reg == $past(neg_reg))
        else $error("falling edge sample not used");

    a_run_after_release: assert property ( // RULE6
        @(posedge pixel_clk_i) disable iff (!prst_n)
        $past(prst_n) |-> pll_run_o)
        else $error("PLL not running after power-down release");

    a_powerdown_reset: assert property ( // RULE17
        @(posedge pixel_clk_i)
        !power_down_n_i |-> !prst_n)
        else $error("pixel reset not applied during power-down");

    a_regs_cleared: assert property ( // RULE7
        @(posedge clk_i) disable iff (rst_i)
        !pd_ok |=> (ctrl_reg == `PVIP_CTRL_RST) && (gpio_reg == `PVIP_GPIO_RST)
            && (&gpio_oe_n_o) && (&register_driven_output_oe_n_o))
        else $error("registers not reset while powered down");

    a_gpio_18bit_only: assert property ( // RULE8
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !m18) |=> &gpio_oe_n_o)
        else $error("general pin driven outside 18-bit mode");

    a_mode18_colour: assert property ( // RULE9
        @(posedge pixel_clk_i) disable iff (!prst_n)
        cfg.mode18 |=> (word_o.red[1:0] == 2'b00) && (word_o.green[1:0] == 2'b00)
            && (word_o.second_audio_data == $past(samp_reg.blue[1])) && !word_o.blue[1])
        else $error("shared colour pins not released in 18-bit mode");

    a_blue_out_drive: assert property ( // RULE10
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pd_ok && gpio_reg[`PVIP_RDO_EN] ) |=> !register_driven_output_oe_n_o[0])
        else $error("blue bit 0 not driven as output");

    a_audio_out_drive: assert property ( // RULE11
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pd_ok && gpio_reg[`PVIP_RDO_EN+3 -: 2] == 2'b11)
        |=> register_driven_output_oe_n_o[3:2] == 2'b00)
        else $error("audio pins not driven as outputs");

    a_out_value: assert property ( // RULE13
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pd_ok) |=> register_driven_output_o == $past(gpio_reg[`PVIP_RDO_VAL +: 4]))
        else $error("register output does not follow its bit");

    a_addr_select: assert property ( // RULE14
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pd_ok && !addr_valid_reg)
        |=> addr_valid_reg && (i2c_target_addr_o == addr_decode($past(asel))))
        else $error("target address not taken from select pin");

endmodule : pvip_top

`default_nettype wire

// File: verif/pvip_video_source.sv
// Video source model: drives the parallel pixel pins on the pixel clock.
// Assumes the bench calls its tasks from one process at a time.
`default_nettype none

module pvip_video_source
    import pvip_pkg::*;
(
    // Pixel clock
    input  wire logic pixel_clk_i,
    // Pixel pins
    output var pvip_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Vertical sync is held low, so it never toggles faster than allowed
    initial begin
        pins_o = '0;
    end

    task automatic set_colour(input logic [23:0] rgb);
        @(posedge pixel_clk_i);
        {pins_o.red, pins_o.green, pins_o.blue} <= rgb;
    endtask : set_colour

    // The long tail keeps each control line to two toggles per 130 clocks
    task automatic ctrl_pulse(input logic is_valid, input int width);
        @(posedge pixel_clk_i);
        if (is_valid) begin
            pins_o.pixel_valid <= 1'b1;
        end else begin
            pins_o.horizontal_sync <= 1'b1;
        end
        repeat (width) @(posedge pixel_clk_i);
        pins_o.pixel_valid     <= 1'b0;
        pins_o.horizontal_sync <= 1'b0;
        repeat (130) @(posedge pixel_clk_i);
    endtask : ctrl_pulse

endmodule : pvip_video_source

`default_nettype wire

// File: verif/test_pvip_top.sv
// Bench of the parallel video input port: Wishbone master, video source model.
// Assumes a 50 MHz bus clock and a free-running 160 ns pixel clock.
`default_nettype none
`include "pvip_defines.svh"

module test_pvip_top;
    import pvip_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] ADDR_TAB [4] = '{7'h2a, 7'h35, 7'h4c, 7'h57};

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pixel_clk_i = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        pwr_n = 1'b1;
    logic        ce = 1'b1;
    logic        mode_sel = 1'b0;
    logic [1:0]  addr_sel = 2'h0;
    pvip_pins_t  src_pins;
    pvip_pins_t  pins_i;
    pvip_word_t  word_o;
    logic        link_p;
    logic        link_n;
    logic        pll_run;
    logic [3:0]  gpio;
    logic [3:0]  gpio_oe_n;
    logic [3:0]  rdo;
    logic [3:0]  rdo_oe_n;
    logic [6:0]  tgt_addr;
    int          num_errors = 0;
    int          n_tests = 0;
    int          hs_cnt = 0;
    int          de_cnt = 0;

    always #10 clk_i = ~clk_i;
    always #80 pixel_clk_i = ~pixel_clk_i;

    // Shared pins carry whatever the device drives while it drives them
    always_comb begin
        pins_i = src_pins;
        for (int i = 0; i < 2; i++) begin
            if (!gpio_oe_n[i]) pins_i.red[i] = gpio[i];
            if (!gpio_oe_n[i+2]) pins_i.green[i] = gpio[i+2];
            if (!rdo_oe_n[i]) pins_i.blue[i] = rdo[i];
        end
        if (!rdo_oe_n[2]) pins_i.audio_data = rdo[2];
        if (!rdo_oe_n[3]) pins_i.audio_word_clk = rdo[3];
    end

    always @(posedge pixel_clk_i) begin
        if (word_o.horizontal_sync === 1'b1) hs_cnt++;
        if (word_o.pixel_valid === 1'b1) de_cnt++;
    end

    pvip_video_source src (.pixel_clk_i(pixel_clk_i), .pins_o(src_pins));

    pvip_top #(
        .ADDR_SEL0(ADDR_TAB[0]), .ADDR_SEL1(ADDR_TAB[1]),
        .ADDR_SEL2(ADDR_TAB[2]), .ADDR_SEL3(ADDR_TAB[3])
    ) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .pixel_clk_i(pixel_clk_i), .pins_i(pins_i), .word_o(word_o),
        .link_p_o(link_p), .link_n_o(link_n), .pll_run_o(pll_run),
        .power_down_n_i(pwr_n), .mode_select_i(mode_sel), .bus_address_select_i(addr_sel),
        .gpio_o(gpio), .gpio_oe_n_o(gpio_oe_n), .register_driven_output_o(rdo),
        .register_driven_output_oe_n_o(rdo_oe_n), .i2c_target_addr_o(tgt_addr)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Holds the request until ack is seen; only the watchdog bounds the wait
    task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= a;
        wb_wdat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb_cycle

    task automatic wb_expect(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(a, 1'b0, 32'h0, q);
        check(name, q, exp);
    endtask : wb_expect

    task automatic wait_ready();
        logic [31:0] q;
        int n;
        n = 0;
        q = '0;
        while (q[`PVIP_STAT_AVALID] !== 1'b1 && n < 50) begin
            wb_cycle(`PVIP_STAT_OFS, 1'b0, 32'h0, q);
            n++;
        end
        check("ready", {31'h0, q[`PVIP_STAT_AVALID]}, 32'h1);
    endtask : wait_ready

    task automatic t_reset();
        logic [31:0] q;
        wb_cycle(8'h0c, 1'b1, 32'hffff_ffff, q);
        wb_expect("ctrl_rst", `PVIP_CTRL_OFS, `PVIP_CTRL_RST);
        wb_expect("gpio_rst", `PVIP_GPIO_OFS, `PVIP_GPIO_RST);
        wb_expect("unmapped", 8'h0c, 32'h0);
        check("gpio_oe_rst", {28'h0, gpio_oe_n}, 32'hf);
        check("rdo_oe_rst", {28'h0, rdo_oe_n}, 32'hf);
    endtask : t_reset

    task automatic filter_case(input logic [31:0] ctrl, input logic is_valid,
                               input int width, input int exp);
        logic [31:0] q;
        wb_cycle(`PVIP_CTRL_OFS, 1'b1, ctrl, q);
        repeat (4) @(posedge pixel_clk_i);
        hs_cnt = 0;
        de_cnt = 0;
        src.ctrl_pulse(is_valid, width);
        check(is_valid ? "valid_width" : "hsync_width", is_valid ? de_cnt : hs_cnt, exp);
    endtask : filter_case

    task automatic t_filter();
        for (int v = 0; v < 2; v++) begin
            filter_case(32'h1, v[0], 2, 0);
            filter_case(32'h1, v[0], 3, 3);
            filter_case(32'h0, v[0], 1, 1);
        end
    endtask : t_filter

    task automatic t_edge();
        logic [31:0] q;
        for (int e = 0; e < 2; e++) begin
            wb_cycle(`PVIP_CTRL_OFS, 1'b1, {30'h0, e[0], 1'b0}, q);
            src.set_colour(24'h5a3c81 ^ {24{e[0]}});
            repeat (4) @(posedge pixel_clk_i);
            check("colour", {8'h0, word_o[27:4]}, {8'h0, 24'h5a3c81 ^ {24{e[0]}}});
        end
    endtask : t_edge

    task automatic t_power_down();
        @(posedge clk_i);
        pwr_n <= 1'b0;
        #1;
        check("word_cleared", {4'h0, word_o}, 32'h0);
        repeat (8) @(posedge clk_i);
        check("link_idle", {30'h0, link_p, link_n}, 32'h3);
        check("pll_stop", {31'h0, pll_run}, 32'h0);
        wb_expect("ctrl_down", `PVIP_CTRL_OFS, `PVIP_CTRL_RST);
        pwr_n <= 1'b1;
        wait_ready();
        // Pixel side leaves power-down two pixel edges after the pin rises
        repeat (4) @(posedge pixel_clk_i);
        check("pll_run", {31'h0, pll_run}, 32'h1);
        check("link_pair", {31'h0, link_p ^ link_n}, 32'h1);
        wb_expect("ctrl_up", `PVIP_CTRL_OFS, `PVIP_CTRL_RST);
    endtask : t_power_down

    task automatic t_rdo();
        logic [31:0] q;
        src.set_colour(24'h0000ff);
        wb_cycle(`PVIP_GPIO_OFS, 1'b1, 32'h0000_aff0, q);
        repeat (4) @(posedge pixel_clk_i);
        check("rdo_val", {28'h0, rdo}, 32'ha);
        check("rdo_oe", {28'h0, rdo_oe_n}, 32'h0);
        check("gpio_oe_24", {28'h0, gpio_oe_n}, 32'hf);
        check("blue_shared", {24'h0, word_o.blue}, 32'hfc);
        wb_cycle(`PVIP_GPIO_OFS, 1'b1, 32'h0, q);
    endtask : t_rdo

    task automatic t_gpio18();
        logic [31:0] q;
        mode_sel <= 1'b1;
        src.set_colour(24'h0102ff);
        repeat (4) @(posedge pixel_clk_i);
        wb_cycle(`PVIP_STAT_OFS, 1'b0, 32'h0, q);
        check("stat_pins", {27'h0, q[4:0]}, 32'h19);
        check("rg_zeroed", {16'h0, word_o.red, word_o.green}, 32'h0);
        check("blue18", {24'h0, word_o.blue}, 32'hfd);
        check("audio2", {31'h0, word_o.second_audio_data}, 32'h1);
        wb_cycle(`PVIP_GPIO_OFS, 1'b1, 32'h0000_aff5, q);
        repeat (4) @(posedge pixel_clk_i);
        check("gpio_val", {28'h0, gpio}, 32'h5);
        check("gpio_oe18", {28'h0, gpio_oe_n}, 32'h0);
        check("rdo_oe18", {28'h0, rdo_oe_n}, 32'h2);
        wb_cycle(`PVIP_STAT_OFS, 1'b0, 32'h0, q);
        check("stat_driven", {28'h0, q[3:0]}, 32'h5);
        wb_cycle(`PVIP_GPIO_OFS, 1'b1, 32'h0, q);
        mode_sel <= 1'b0;
    endtask : t_gpio18

    task automatic t_address();
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            addr_sel <= i[1:0];
            pwr_n    <= 1'b0;
            repeat (8) @(posedge clk_i);
            pwr_n <= 1'b1;
            wait_ready();
            wb_cycle(`PVIP_STAT_OFS, 1'b0, 32'h0, q);
            check("target_addr", {25'h0, tgt_addr}, {25'h0, ADDR_TAB[i]});
            check("stat_addr", {25'h0, q[11:5]}, {25'h0, ADDR_TAB[i]});
        end
    endtask : t_address

    // A request made while the enable is low must wait; it also sets 18-bit mode
    task automatic t_clock_enable();
        logic [31:0] q;
        @(posedge clk_i);
        ce <= 1'b0;
        fork
            wb_cycle(`PVIP_CTRL_OFS, 1'b1, 32'h0000_0004, q);
            begin
                repeat (4) @(posedge clk_i);
                check("ce_stall", {31'h0, wb_ack}, 32'h0);
                ce <= 1'b1;
            end
        join
        wb_expect("ce_write", `PVIP_CTRL_OFS, 32'h0000_0004);
        wb_cycle(`PVIP_STAT_OFS, 1'b0, 32'h0, q);
        check("m18_reg", {31'h0, q[`PVIP_STAT_M18]}, 32'h1);
    endtask : t_clock_enable

    initial begin
        #1_000_000;
        num_errors++;
        print_verdict();
    end

    initial begin
        // The pixel side is reset only by a falling power-down pin
        @(posedge clk_i);
        pwr_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        pwr_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        wait_ready();
        t_reset();
        t_filter();
        t_edge();
        t_power_down();
        t_rdo();
        t_gpio18();
        t_address();
        t_clock_enable();
        print_verdict();
    end

endmodule : test_pvip_top

`default_nettype wire
